// [core/pie_core.sv]
// pie_core: peripheral interrupt expander for cpu levels three and five
// assumes one-cycle event pulses from peripherals on clk, and a core that
// acknowledges one level at a time and reads the vector afterwards
//
// Functional notes
// - timer b period: pending 1.0, level three, rank 28, code 002bh
// - timer b compare: pending 1.1, level three, rank 29, code 002ch
// - timer b underflow: pending 1.2, level three, rank 30, code 002dh
// - timer b overflow: pending 1.3, level three, rank 31, code 002eh
// - timer d period: pending 2.8, level three, rank 32, code 0039h
// - timer d compare: pending 2.9, level three, rank 33, code 003ah
// - timer d underflow: pending 2.10, level three, rank 34, code 003bh
// - timer d overflow: pending 2.11, level three, rank 35, code 003ch
// - serial peripheral: pending 1.7, level five, rank 42, code 0005h
// - async receive: pending 1.8, level five, rank 43, code 0006h
// - async transmit: pending 1.9, level five, rank 44, code 0007h
// - can mailbox: pending 1.10, level five, rank 45, code 0040h
// - can error: pending 1.11, level five, rank 46, code 0041h
`timescale 1ns/1ps
`default_nettype none
module pie_core (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // peripheral event pulses
    input  wire logic                      timer_b_period_irq,
    input  wire logic                      timer_b_compare_irq,
    input  wire logic                      timer_b_underflow_irq,
    input  wire logic                      timer_b_overflow_irq,
    input  wire logic                      timer_d_period_irq,
    input  wire logic                      timer_d_compare_irq,
    input  wire logic                      timer_d_underflow_irq,
    input  wire logic                      timer_d_overflow_irq,
    input  wire logic                      serial_periph_irq,
    input  wire logic                      async_receive_irq,
    input  wire logic                      async_transmit_irq,
    input  wire logic                      can_mailbox_irq,
    input  wire logic                      can_error_irq,
    // cpu level requests and acknowledge
    output logic                           cpu_level_three,
    output logic                           cpu_level_five,
    input  wire logic                      ack_level_three,
    input  wire logic                      ack_level_five,
    output logic [pie_pkg::PIE_VEC_W-1:0]  peripheral_vector_code,
    output logic                           vector_valid,
    // register port
    input  wire logic [pie_pkg::PIE_ADDR_W-1:0] reg_addr,
    input  wire logic [pie_pkg::PIE_DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [pie_pkg::PIE_DATA_W-1:0] reg_rdata,
    // interrupt to system
    output logic                           irq
);
    import pie_pkg::*;

    logic [PIE_NSRC-1:0] evt;
    logic [PIE_NSRC-1:0] pend_reg;
    logic [PIE_NSRC-1:0] en_reg;
    logic [PIE_NSRC-1:0] live;
    logic [PIE_NSRC-1:0] ack_clr;
    logic [PIE_NSRC-1:0] sw_clr;
    logic [PIE_NSRC-1:0] sw_en;
    logic [15:0]         grp1_pend;
    logic [15:0]         grp2_pend;
    logic [15:0]         grp1_en;
    logic [15:0]         grp2_en;
    logic [PIE_ST_W-1:0] stat_reg;
    logic [PIE_ST_W-1:0] mask_reg;
    logic [PIE_ST_W-1:0] stat_set;
    logic                hit3;
    logic                hit5;
    logic [2:0]          idx3;
    logic [2:0]          idx5;
    logic [3:0]          win;
    logic                win_ok;
    pie_ack_t            ack_sel;

    // maps a source into its 16-bit flag group image
    function automatic logic [15:0] pie_to_grp(input logic [PIE_NSRC-1:0] v,
                                               input logic [1:0] g);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < PIE_NSRC; i++) begin
            if (PIE_GRP[i] == g)
                r[PIE_BIT[i]] = v[i];
        end
        return r;
    endfunction

    // picks a source's bit out of a group image written by software
    function automatic logic [PIE_NSRC-1:0] pie_from_grp(input logic [15:0] d,
                                                         input logic [1:0] g);
        logic [PIE_NSRC-1:0] r;
        r = '0;
        for (int i = 0; i < PIE_NSRC; i++) begin
            if (PIE_GRP[i] == g)
                r[i] = d[PIE_BIT[i]];
        end
        return r;
    endfunction

    assign evt = {can_error_irq, can_mailbox_irq, async_transmit_irq,
                  async_receive_irq, serial_periph_irq,
                  timer_d_overflow_irq, timer_d_underflow_irq,
                  timer_d_compare_irq, timer_d_period_irq,
                  timer_b_overflow_irq, timer_b_underflow_irq,
                  timer_b_compare_irq, timer_b_period_irq};

    assign grp1_pend = pie_to_grp(pend_reg, 2'd1);
    assign grp2_pend = pie_to_grp(pend_reg, 2'd2);
    assign grp1_en   = pie_to_grp(en_reg, 2'd1);
    assign grp2_en   = pie_to_grp(en_reg, 2'd2);

    assign live = pend_reg & en_reg;

    // level three picker: timer b then timer d, ranks 28..35
    pie_pick #(
        .N (8)
    ) u_pick3 (
        .req (live[PIE_L3_LAST:PIE_L3_FIRST]),
        .hit (hit3),
        .idx (idx3)
    );

    // level five picker: serial, async, can, ranks 42..46
    pie_pick #(
        .N (5)
    ) u_pick5 (
        .req (live[PIE_L5_LAST:PIE_L5_FIRST]),
        .hit (hit5),
        .idx (idx5)
    );

    // level three takes the acknowledge if both arrive despite the protocol
    always_comb begin
        if (ack_level_three)
            ack_sel = PIE_ACK_L3;
        else if (ack_level_five)
            ack_sel = PIE_ACK_L5;
        else
            ack_sel = PIE_ACK_IDLE;
    end

    always_comb begin
        win    = 4'd0;
        win_ok = 1'b0;
        case (ack_sel)
            PIE_ACK_L3: begin
                win    = {1'b0, idx3};
                win_ok = hit3;
            end
            PIE_ACK_L5: begin
                win    = 4'(PIE_L5_FIRST) + {1'b0, idx5};
                win_ok = hit5;
            end
            default: begin
                win    = 4'd0;
                win_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        ack_clr = '0;
        if (win_ok)
            ack_clr[win] = 1'b1;
    end

    always_comb begin
        sw_clr = '0;
        if (reg_wr && reg_addr == PIE_OFF_PEND1)
            sw_clr = pie_from_grp(reg_wdata, 2'd1);
        else if (reg_wr && reg_addr == PIE_OFF_PEND2)
            sw_clr = pie_from_grp(reg_wdata, 2'd2);
    end

    // pending flags: a new event outranks any clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~ack_clr & ~sw_clr) | evt;
        end
    end

    always_comb begin
        sw_en = en_reg;
        if (reg_wr && reg_addr == PIE_OFF_EN1)
            sw_en = (en_reg & ~pie_from_grp(16'hffff, 2'd1)) | pie_from_grp(reg_wdata, 2'd1);
        else if (reg_wr && reg_addr == PIE_OFF_EN2)
            sw_en = (en_reg & ~pie_from_grp(16'hffff, 2'd2)) | pie_from_grp(reg_wdata, 2'd2);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_reg <= pie_from_grp(PIE_EN_RST, 2'd1) | pie_from_grp(PIE_EN_RST, 2'd2);
        end else begin
            en_reg <= sw_en;
        end
    end

    // cpu level requests follow live sources, no extra latency
    assign cpu_level_three = |live[PIE_L3_LAST:PIE_L3_FIRST];
    assign cpu_level_five  = |live[PIE_L5_LAST:PIE_L5_FIRST];

    // vector register holds the last answer until the next acknowledge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            peripheral_vector_code <= PIE_VEC_PHANTOM;
            vector_valid           <= 1'b0;
        end else begin
            vector_valid <= (ack_sel != PIE_ACK_IDLE);
            if (ack_sel != PIE_ACK_IDLE) begin
                if (win_ok)
                    peripheral_vector_code <= PIE_VEC[win];
                else
                    peripheral_vector_code <= PIE_VEC_PHANTOM;
            end
        end
    end

    // status events: spurious acknowledge, and event on an already set flag
    always_comb begin
        stat_set = '0;
        stat_set[PIE_ST_SPUR] = (ack_sel != PIE_ACK_IDLE) && !win_ok;
        stat_set[PIE_ST_LOST] = |(evt & pend_reg & ~ack_clr & ~sw_clr);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_reg <= '0;
        end else if (reg_wr && reg_addr == PIE_OFF_STAT) begin
            stat_reg <= (stat_reg & ~reg_wdata[PIE_ST_W-1:0]) | stat_set;
        end else begin
            stat_reg <= stat_reg | stat_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= PIE_MASK_RST[PIE_ST_W-1:0];
        end else if (reg_wr && reg_addr == PIE_OFF_MASK) begin
            mask_reg <= reg_wdata[PIE_ST_W-1:0];
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // read data stands in the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                PIE_OFF_PEND1: reg_rdata <= grp1_pend;
                PIE_OFF_PEND2: reg_rdata <= grp2_pend;
                PIE_OFF_EN1:   reg_rdata <= grp1_en;
                PIE_OFF_EN2:   reg_rdata <= grp2_en;
                PIE_OFF_VEC:   reg_rdata <= peripheral_vector_code;
                PIE_OFF_STAT:  reg_rdata <= {{(PIE_DATA_W-PIE_ST_W){1'b0}}, stat_reg};
                PIE_OFF_MASK:  reg_rdata <= {{(PIE_DATA_W-PIE_ST_W){1'b0}}, mask_reg};
                default:       reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// [pkg/pie_pkg.sv]
// pie_pkg: constants for the peripheral interrupt expander
// assumes a single 20 MHz clock domain; no timing counts are needed
package pie_pkg;

    localparam int PIE_NSRC = 13;
    localparam int PIE_VEC_W = 16;
    localparam int PIE_ADDR_W = 4;
    localparam int PIE_DATA_W = 16;

    // source index order is also the fixed overall rank order
    localparam int PIE_SRC_T2P = 0;
    localparam int PIE_SRC_T2C = 1;
    localparam int PIE_SRC_T2U = 2;
    localparam int PIE_SRC_T2O = 3;
    localparam int PIE_SRC_T4P = 4;
    localparam int PIE_SRC_T4C = 5;
    localparam int PIE_SRC_T4U = 6;
    localparam int PIE_SRC_T4O = 7;
    localparam int PIE_SRC_SPI = 8;
    localparam int PIE_SRC_RX  = 9;
    localparam int PIE_SRC_TX  = 10;
    localparam int PIE_SRC_CMB = 11;
    localparam int PIE_SRC_CER = 12;
    localparam int PIE_L3_FIRST = 0;
    localparam int PIE_L3_LAST  = 7;
    localparam int PIE_L5_FIRST = 8;
    localparam int PIE_L5_LAST  = 12;

    // overall rank of each source
    localparam logic [5:0] PIE_RANK [PIE_NSRC] = '{
        6'd28, 6'd29, 6'd30, 6'd31, 6'd32, 6'd33, 6'd34, 6'd35,
        6'd42, 6'd43, 6'd44, 6'd45, 6'd46};

    // peripheral vector codes
    localparam logic [15:0] PIE_VEC [PIE_NSRC] = '{
        16'h002b, 16'h002c, 16'h002d, 16'h002e,
        16'h0039, 16'h003a, 16'h003b, 16'h003c,
        16'h0005, 16'h0006, 16'h0007, 16'h0040, 16'h0041};
    localparam logic [15:0] PIE_VEC_PHANTOM = 16'h0000;

    // cpu level vector addresses
    localparam logic [15:0] PIE_CPU_VEC_L3 = 16'h0006;
    localparam logic [15:0] PIE_CPU_VEC_L5 = 16'h000a;

    // pending flag group positions: group number and bit
    localparam logic [1:0] PIE_GRP [PIE_NSRC] = '{
        2'd1, 2'd1, 2'd1, 2'd1, 2'd2, 2'd2, 2'd2, 2'd2,
        2'd1, 2'd1, 2'd1, 2'd1, 2'd1};
    localparam logic [3:0] PIE_BIT [PIE_NSRC] = '{
        4'd0, 4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11,
        4'd7, 4'd8, 4'd9, 4'd10, 4'd11};

    // register map (word offsets on the plain register port)
    localparam logic [3:0] PIE_OFF_PEND1 = 4'h0;
    localparam logic [3:0] PIE_OFF_PEND2 = 4'h1;
    localparam logic [3:0] PIE_OFF_EN1   = 4'h2;
    localparam logic [3:0] PIE_OFF_EN2   = 4'h3;
    localparam logic [3:0] PIE_OFF_VEC   = 4'h4;
    localparam logic [3:0] PIE_OFF_STAT  = 4'h5;
    localparam logic [3:0] PIE_OFF_MASK  = 4'h6;
    localparam logic [15:0] PIE_EN_RST   = 16'h0000;
    localparam logic [15:0] PIE_MASK_RST = 16'h0000;

    // status event bits
    localparam int PIE_ST_SPUR = 0;
    localparam int PIE_ST_LOST = 1;
    localparam int PIE_ST_W    = 2;

    typedef enum logic [1:0] {
        PIE_ACK_IDLE = 2'b00,
        PIE_ACK_L3   = 2'b01,
        PIE_ACK_L5   = 2'b10
    } pie_ack_t;

endpackage

// [core/pie_pick.sv]
// pie_pick: fixed priority picker over one cpu level
// assumes pending/enable vectors in rank order, index 0 highest
`timescale 1ns/1ps
`default_nettype none
module pie_pick #(
    parameter int N = 8
) (
    // candidates
    input  wire logic [N-1:0] req,
    // result
    output logic              hit,
    output logic [$clog2(N)-1:0] idx
);
    import pie_pkg::*;

    // lowest index wins, which is the lowest rank number
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                hit = 1'b1;
                idx = i[$clog2(N)-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// [test/pie_cpu_model.sv]
// pie_cpu_model: processor core that acknowledges one level per command
// assumes the bench pulses ack_cmd for one cycle per acknowledge
`timescale 1ns/1ps
`default_nettype none
module pie_cpu_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // bench command and expander side
    input wire logic [1:0] ack_cmd,
    input wire logic       vector_valid,
    output logic           ack_level_three,
    output logic           ack_level_five
);
    logic wait_reg;
    // no new acknowledge until the last code was read; three wins a tie
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_level_three <= 1'b0;
            ack_level_five  <= 1'b0;
            wait_reg        <= 1'b0;
        end else begin
            ack_level_three <= ack_cmd[0] && !wait_reg;
            ack_level_five  <= ack_cmd == 2'b10 && !wait_reg;
            wait_reg        <= !vector_valid && (wait_reg || ack_cmd != 2'b00);
        end
    end
endmodule
`default_nettype wire

// [test/pie_core_chk.sv]
// pie_core_chk: port assertions for the interrupt expander
// assumes one clock domain with an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module pie_core_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // cpu side and register port
    input wire logic        cpu_level_three,
    input wire logic        cpu_level_five,
    input wire logic        ack_level_three,
    input wire logic        ack_level_five,
    input wire logic [15:0] peripheral_vector_code,
    input wire logic        vector_valid,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata
);
    logic any_ack;
    assign any_ack = ack_level_three | ack_level_five;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_ack_answer: assert property (any_ack |=> vector_valid)
        else $error("no code after ack");
    a_valid_single: assert property (any_ack ##1 !any_ack |=> !vector_valid)
        else $error("code flag too long");
    a_code_steady: assert property (!vector_valid |-> $stable(peripheral_vector_code))
        else $error("code moved without ack");
    a_phantom_three: assert property ((ack_level_three && !cpu_level_three)
        |=> peripheral_vector_code == 16'h0000) else $error("no phantom code");
    a_phantom_five: assert property ((ack_level_five && !ack_level_three && !cpu_level_five)
        |=> peripheral_vector_code == 16'h0000) else $error("no phantom code");
    a_three_codes: assert property ((ack_level_three && cpu_level_three)
        |=> peripheral_vector_code inside {[16'h002b:16'h002e], [16'h0039:16'h003c]})
        else $error("bad level three code");
    a_five_codes: assert property ((ack_level_five && !ack_level_three
        && cpu_level_five) |=> peripheral_vector_code inside {[16'h0005:16'h0007],
        [16'h0040:16'h0041]})
        else $error("bad level five code");
    a_unmapped_read: assert property ((reg_rd && reg_addr > 4'h6) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    c_ack_three: cover property (ack_level_three && cpu_level_three);
    c_phantom: cover property (ack_level_five && !cpu_level_five);
    c_ack_burst: cover property (any_ack ##3 any_ack);
endmodule
bind pie_core pie_core_chk u_chk (
    .clk, .rst_b, .cpu_level_three, .cpu_level_five, .ack_level_three, .ack_level_five,
    .peripheral_vector_code, .vector_valid, .reg_addr, .reg_rd, .reg_rdata
);
`default_nettype wire

// [test/test_pie_core.sv]
// test_pie_core: directed bench for the peripheral interrupt expander
// assumes pie_core, pie_cpu_model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module test_pie_core;
    import pie_pkg::*;
    localparam logic WR = 1'b1, RD = 1'b0;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [12:0] ev = '0;
    logic [1:0]  cmd = '0;
    logic [3:0]  addr = '0;
    logic [15:0] wdata = '0, code, rdata;
    logic        ack3, ack5, lvl3, lvl5, vv, irq;
    int          fails = 0, num_checks = 0;
    initial forever #25 clk = ~clk;
    pie_core dut (
        .clk, .rst_b, .timer_b_period_irq(ev[0]), .timer_b_compare_irq(ev[1]),
        .timer_b_underflow_irq(ev[2]), .timer_b_overflow_irq(ev[3]),
        .timer_d_period_irq(ev[4]), .timer_d_compare_irq(ev[5]),
        .timer_d_underflow_irq(ev[6]), .timer_d_overflow_irq(ev[7]),
        .serial_periph_irq(ev[8]), .async_receive_irq(ev[9]), .async_transmit_irq(ev[10]),
        .can_mailbox_irq(ev[11]), .can_error_irq(ev[12]), .cpu_level_three(lvl3),
        .cpu_level_five(lvl5), .ack_level_three(ack3), .ack_level_five(ack5),
        .peripheral_vector_code(code), .vector_valid(vv), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq
    );
    pie_cpu_model cpu (
        .clk, .rst_b, .ack_cmd(cmd), .vector_valid(vv),
        .ack_level_three(ack3), .ack_level_five(ack5)
    );
    task automatic close_out;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access: a write, or a read compared in the cycle after its strobe
    task automatic reg_op(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        #1;
        if (!w)
            chk(rdata, d);
    endtask
    task automatic pulse(input logic [12:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask
    task automatic ack(input logic [1:0] lv, input logic [15:0] exp);
        int k = 0;
        @(posedge clk);
        cmd <= lv;
        @(posedge clk);
        cmd <= 2'b00;
        do begin
            @(posedge clk);
            #1 k++;
        end while (vv !== 1'b1 && k < 8);
        chk({15'h0, vv}, 16'h0001);
        chk(code, exp);
        if (vv !== 1'b1)
            close_out();
    endtask
    function automatic logic [15:0] vec(input int i);
        return 16'(i < 4 ? 'h2b + i : (i < 8 || i > 10) ? 'h35 + i : i - 3);
    endfunction
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 16; a++)
            reg_op(RD, 4'(a), 16'h0000);
        // a flag latches while disabled but requests nothing
        pulse(13'h0001);
        chk(16'(lvl3), 16'h0000);
        reg_op(RD, PIE_OFF_PEND1, 16'h0001);
        $display("test reset done");
        reg_op(WR, PIE_OFF_EN1, 16'h0f8f);
        reg_op(WR, PIE_OFF_EN2, 16'h0f00);
        for (int i = 0; i < 13; i++) begin
            logic [3:0] g;
            int         b;
            g = (i > 3 && i < 8) ? PIE_OFF_PEND2 : PIE_OFF_PEND1;
            b = i < 4 ? i : i < 8 ? i + 4 : i - 1;
            pulse(13'(1 << i));
            reg_op(RD, g, 16'(1 << b));
            chk(16'(i < 8 ? lvl3 : lvl5), 16'h0001);
            ack(i < 8 ? 2'b01 : 2'b10, vec(i));
            reg_op(RD, PIE_OFF_VEC, vec(i));
            reg_op(RD, g, 16'h0000);
        end
        $display("test sources done");
        reg_op(WR, PIE_OFF_EN1, 16'h0f8e);
        pulse(13'h1fff);
        for (int i = 8; i < 13; i++)
            ack(2'b10, vec(i));
        ack(2'b10, 16'h0000);
        for (int i = 1; i < 8; i++)
            ack(2'b01, vec(i));
        ack(2'b01, 16'h0000);
        reg_op(RD, PIE_OFF_PEND1, 16'h0001);
        reg_op(WR, PIE_OFF_PEND1, 16'h0001);
        reg_op(RD, PIE_OFF_PEND1, 16'h0000);
        $display("test priority done");
        chk(16'(irq), 16'h0000);
        reg_op(WR, PIE_OFF_MASK, 16'h0001);
        reg_op(RD, PIE_OFF_MASK, 16'h0001);
        chk(16'(irq), 16'h0001);
        reg_op(RD, PIE_OFF_STAT, 16'h0003);
        reg_op(WR, PIE_OFF_STAT, 16'h0003);
        chk(16'(irq), 16'h0000);
        $display("test interrupt done");
        close_out();
    end
endmodule
`default_nettype wire
